// File: rtl/rtcal_pkg.sv
/*
 * constants for the alarm match and multi-function output block:
 * register offsets, field positions, reset values, match selects.
 * assumes 8-bit registers reached by a plain address/strobe port.
 */
package rtcal_pkg;
	// register offsets
	localparam logic [7:0] A_CTRL   = 8'h08;
	localparam logic [7:0] A0_SEC   = 8'h0c;
	localparam logic [7:0] A0_MIN   = 8'h0d;
	localparam logic [7:0] A0_HOUR  = 8'h0e;
	localparam logic [7:0] A0_WKD   = 8'h0f;
	localparam logic [7:0] A0_DATE  = 8'h10;
	localparam logic [7:0] A0_MTH   = 8'h11;
	localparam logic [7:0] A1_HSEC  = 8'h12;
	localparam logic [7:0] A1_SEC   = 8'h13;
	localparam logic [7:0] A1_MIN   = 8'h14;
	localparam logic [7:0] A1_HOUR  = 8'h15;
	localparam logic [7:0] A1_WKD   = 8'h16;
	localparam logic [7:0] A1_DATE  = 8'h17;

	// control bit positions
	localparam int C_SQW = 6;
	localparam int C_AL1 = 5;
	localparam int C_AL0 = 4;
	localparam int C_EXT = 3;
	localparam int C_CRS = 2;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic       CTRL_B7  = 1'b1;

	// weekday register fields
	localparam int W_IF = 3;

	// reset values
	localparam logic [2:0] R_WKD  = 3'h1;
	localparam logic [5:0] R_DATE = 6'h01;
	localparam logic [4:0] R_MTH  = 5'h01;
	localparam logic       MFP_IDLE = 1'b1;

	// hour format bit of the running hour value
	localparam int H_FMT = 6;

	// output rate select and divider taps
	localparam logic [1:0] FS_1HZ  = 2'h0;
	localparam logic [1:0] FS_DIV8 = 2'h1;
	localparam logic [1:0] FS_DIV4 = 2'h2;
	localparam int T_1HZ  = 15;
	localparam int T_DIV8 = 3;
	localparam int T_DIV4 = 2;

	typedef enum logic [2:0] {
		SEL_SEC  = 3'h0,
		SEL_MIN  = 3'h1,
		SEL_HOUR = 3'h2,
		SEL_WKD  = 3'h3,
		SEL_DATE = 3'h4,
		SEL_HSEC = 3'h5,
		SEL_RSV  = 3'h6,
		SEL_ALL  = 3'h7
	} rtcal_sel_e;
endpackage

// File: rtl/rtcal_time_if.sv
/*
 * running time fields, in bcd, with the timekeeping tick.
 * assumes one driver (the top) and any number of readers.
 */
`timescale 1ns/1ps
interface rtcal_time_if;
	logic       tick;
	logic [7:0] hsec;
	logic [6:0] sec;
	logic [6:0] min;
	logic [5:0] hour;
	logic [2:0] wkd;
	logic [5:0] date;
	logic [4:0] mth;
	modport src (output tick, hsec, sec, min, hour, wkd, date, mth);
	modport dst (input tick, hsec, sec, min, hour, wkd, date, mth);
endinterface

// File: rtl/rtcal_match.sv
/*
 * match detector for one alarm: compares the selected bcd fields
 * with the running time on each tick and pulses hit once.
 * assumes tick is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
module rtcal_match #(
	parameter bit ALM0 = 1'b1
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// running time
	rtcal_time_if.dst       t,
	// alarm settings
	input  wire logic       en,
	input  wire logic [2:0] sel,
	input  wire logic [7:0] a_hsec,
	input  wire logic [6:0] a_sec,
	input  wire logic [6:0] a_min,
	input  wire logic [5:0] a_hour,
	input  wire logic [2:0] a_wkd,
	input  wire logic [5:0] a_date,
	input  wire logic [4:0] a_mth,
	// match event
	output logic            hit
);
	function automatic logic f_is(input logic [2:0] s,
		input rtcal_pkg::rtcal_sel_e c);
		return s == c;
	endfunction

	logic eq_last;

	// whole-digit compares keep bcd intact
	wire e_hs = t.hsec == a_hsec;
	wire e_s  = t.sec == a_sec;
	wire e_m  = t.min == a_min;
	// am/pm sits in bit 5 in 12-hour form, so it is compared too
	wire e_h  = t.hour == a_hour;
	wire e_w  = t.wkd == a_wkd;
	wire e_d  = t.date == a_date;
	wire e_mo = !ALM0 || t.mth == a_mth;
	wire e_all = e_s & e_m & e_h & e_w & e_d & e_mo;
	wire e_hsv = !ALM0 && e_hs;

	// reserved codes give no match
	wire eq =
		f_is(sel, rtcal_pkg::SEL_SEC)  ? e_s :
		f_is(sel, rtcal_pkg::SEL_MIN)  ? e_m :
		f_is(sel, rtcal_pkg::SEL_HOUR) ? e_h :
		f_is(sel, rtcal_pkg::SEL_WKD)  ? e_w :
		f_is(sel, rtcal_pkg::SEL_DATE) ? e_d :
		f_is(sel, rtcal_pkg::SEL_HSEC) ? e_hsv :
		f_is(sel, rtcal_pkg::SEL_ALL)  ? e_all : 1'b0;

	// tracked while disabled too, so enabling on a standing match
	// waits for the next time the fields become equal
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			eq_last <= 1'b0;
		else if (t.tick)
			eq_last <= eq;
	end

	assign hit = t.tick & en & eq & !eq_last;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_en_gate;
		!en |-> !hit;
	endproperty
	a_en_gate: assert property (p_en_gate)
		else $error("alarm hit while disabled");

	property p_once;
		hit |=> !hit ##1 !hit;
	endproperty
	a_once: assert property (p_once)
		else $error("alarm hit repeated");

	property p_rsv;
		sel == rtcal_pkg::SEL_RSV |-> !hit;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved select produced a hit");
endmodule

// File: rtl/rtcal_top.sv
/*
 * alarm registers, two alarm matchers and the multi-function pin
 * with its square-wave divider, plus the control register.
 * assumes the serial front end gives one-cycle reg_wr/reg_rd
 * strobes, timekeeping gives bcd time with a tick, and the trim
 * logic gives trimmed oscillator edges.
 */
`timescale 1ns/1ps
module rtcal_top (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// running time, bcd
	input  wire logic       time_tick,
	input  wire logic [7:0] now_hsec,
	input  wire logic [6:0] now_sec,
	input  wire logic [6:0] now_min,
	input  wire logic [7:0] now_hour,
	input  wire logic [2:0] now_weekday_value,
	input  wire logic [5:0] now_date,
	input  wire logic [4:0] now_month,
	// oscillator and power
	input  wire logic       osc_edge,
	input  wire logic       trim_edge,
	input  wire logic       crystal_input_pin,
	input  wire logic       on_backup,
	// outputs
	output logic            multi_function_pin,
	output logic            external_clock_input_enable,
	output logic            coarse_trim_enable
);
	function automatic logic f_wr(input logic s,
		input logic [7:0] a, input logic [7:0] b);
		return s && a == b;
	endfunction

	rtcal_time_if tif ();

	logic [6:0]  ctrl;
	logic [6:0]  a0_sec;
	logic [6:0]  a0_min;
	logic [5:0]  a0_hour;
	logic [2:0]  a0_sel;
	logic [2:0]  a0_wkd;
	logic [5:0]  a0_date;
	logic [4:0]  a0_mth;
	logic [7:0]  a1_hsec;
	logic [6:0]  a1_sec;
	logic [6:0]  a1_min;
	logic [5:0]  a1_hour;
	logic [2:0]  a1_sel;
	logic [2:0]  a1_wkd;
	logic [5:0]  a1_date;
	logic [1:0]  flag;
	logic [1:0]  next_flag;
	logic [1:0]  hit;
	logic        x1_m;
	logic        x1_s;
	logic        x1_d;
	logic        bk_m;
	logic        bk_s;
	logic        raw_tog;
	logic [15:0] div;
	logic        next_mfp;

	// running time onto the shared carrier
	assign tif.tick = time_tick;
	assign tif.hsec = now_hsec;
	assign tif.sec  = now_sec;
	assign tif.min  = now_min;
	assign tif.hour = now_hour[5:0];
	assign tif.wkd  = now_weekday_value;
	assign tif.date = now_date;
	assign tif.mth  = now_month;

	// write decode
	wire wr_ctrl = f_wr(reg_wr, reg_addr, rtcal_pkg::A_CTRL);
	wire wr_0s = f_wr(reg_wr, reg_addr, rtcal_pkg::A0_SEC);
	wire wr_0m = f_wr(reg_wr, reg_addr, rtcal_pkg::A0_MIN);
	wire wr_0h = f_wr(reg_wr, reg_addr, rtcal_pkg::A0_HOUR);
	wire wr_0w = f_wr(reg_wr, reg_addr, rtcal_pkg::A0_WKD);
	wire wr_0d = f_wr(reg_wr, reg_addr, rtcal_pkg::A0_DATE);
	wire wr_0o = f_wr(reg_wr, reg_addr, rtcal_pkg::A0_MTH);
	wire wr_1c = f_wr(reg_wr, reg_addr, rtcal_pkg::A1_HSEC);
	wire wr_1s = f_wr(reg_wr, reg_addr, rtcal_pkg::A1_SEC);
	wire wr_1m = f_wr(reg_wr, reg_addr, rtcal_pkg::A1_MIN);
	wire wr_1h = f_wr(reg_wr, reg_addr, rtcal_pkg::A1_HOUR);
	wire wr_1w = f_wr(reg_wr, reg_addr, rtcal_pkg::A1_WKD);
	wire wr_1d = f_wr(reg_wr, reg_addr, rtcal_pkg::A1_DATE);

	// control fields
	wire sqw = ctrl[rtcal_pkg::C_SQW];
	wire crs = ctrl[rtcal_pkg::C_CRS];
	wire [1:0] fs = ctrl[1:0];
	assign external_clock_input_enable = ctrl[rtcal_pkg::C_EXT];
	assign coarse_trim_enable = crs;

	// registers hold only implemented bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ctrl <= rtcal_pkg::CTRL_RST;
		else if (wr_ctrl)
			ctrl <= reg_wdata[6:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a0_sec <= '0;
		else if (wr_0s)
			a0_sec <= reg_wdata[6:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a0_min <= '0;
		else if (wr_0m)
			a0_min <= reg_wdata[6:0];
	end

	// format bit is not stored; it mirrors the running hour
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a0_hour <= '0;
		else if (wr_0h)
			a0_hour <= reg_wdata[5:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a0_sel <= rtcal_pkg::SEL_SEC;
			a0_wkd <= rtcal_pkg::R_WKD;
		end else if (wr_0w) begin
			a0_sel <= reg_wdata[6:4];
			a0_wkd <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a0_date <= rtcal_pkg::R_DATE;
		else if (wr_0d)
			a0_date <= reg_wdata[5:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a0_mth <= rtcal_pkg::R_MTH;
		else if (wr_0o)
			a0_mth <= reg_wdata[4:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a1_hsec <= '0;
		else if (wr_1c)
			a1_hsec <= reg_wdata;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a1_sec <= '0;
		else if (wr_1s)
			a1_sec <= reg_wdata[6:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a1_min <= '0;
		else if (wr_1m)
			a1_min <= reg_wdata[6:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a1_hour <= '0;
		else if (wr_1h)
			a1_hour <= reg_wdata[5:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a1_sel <= rtcal_pkg::SEL_SEC;
			a1_wkd <= rtcal_pkg::R_WKD;
		end else if (wr_1w) begin
			a1_sel <= reg_wdata[6:4];
			a1_wkd <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			a1_date <= rtcal_pkg::R_DATE;
		else if (wr_1d)
			a1_date <= reg_wdata[5:0];
	end

	rtcal_match #(.ALM0(1'b1)) u_m0 (
		.clk    (clk),
		.arst_n (arst_n),
		.t      (tif.dst),
		.en     (ctrl[rtcal_pkg::C_AL0]),
		.sel    (a0_sel),
		.a_hsec (a1_hsec),
		.a_sec  (a0_sec),
		.a_min  (a0_min),
		.a_hour (a0_hour),
		.a_wkd  (a0_wkd),
		.a_date (a0_date),
		.a_mth  (a0_mth),
		.hit    (hit[0])
	);

	// month field is ignored by the second matcher
	rtcal_match #(.ALM0(1'b0)) u_m1 (
		.clk    (clk),
		.arst_n (arst_n),
		.t      (tif.dst),
		.en     (ctrl[rtcal_pkg::C_AL1]),
		.sel    (a1_sel),
		.a_hsec (a1_hsec),
		.a_sec  (a1_sec),
		.a_min  (a1_min),
		.a_hour (a1_hour),
		.a_wkd  (a1_wkd),
		.a_date (a1_date),
		.a_mth  (a0_mth),
		.hit    (hit[1])
	);

	// set beats a clear in the same cycle; a written 1 does nothing
	wire clr0 = wr_0w && !reg_wdata[rtcal_pkg::W_IF];
	wire clr1 = wr_1w && !reg_wdata[rtcal_pkg::W_IF];
	assign next_flag[0] = hit[0] | (flag[0] & !clr0);
	assign next_flag[1] = hit[1] | (flag[1] & !clr1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			flag <= '0;
		else
			flag <= next_flag;
	end

	// pin and supply status cross in through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			x1_m <= 1'b0;
			x1_s <= 1'b0;
			x1_d <= 1'b0;
			bk_m <= 1'b0;
			bk_s <= 1'b0;
		end else begin
			x1_m <= crystal_input_pin;
			x1_s <= x1_m;
			x1_d <= x1_s;
			bk_m <= on_backup;
			bk_s <= bk_m;
		end
	end

	// both edges of the selected source drive the undivided output
	wire pin_edge = x1_s ^ x1_d;
	wire raw_edge = external_clock_input_enable ? pin_edge : osc_edge;

	// untrimmed path for the 1:1 rate only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			raw_tog <= 1'b0;
		else if (raw_edge)
			raw_tog <= !raw_tog;
	end

	// divided rates count trimmed edges, two per oscillator period
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			div <= '0;
		else if (trim_edge)
			div <= div + 16'h0001;
	end

	wire sq_rate =
		(fs == rtcal_pkg::FS_1HZ)  ? div[rtcal_pkg::T_1HZ] :
		(fs == rtcal_pkg::FS_DIV8) ? div[rtcal_pkg::T_DIV8] :
		(fs == rtcal_pkg::FS_DIV4) ? div[rtcal_pkg::T_DIV4] :
		raw_tog;
	wire sq_out = crs ? div[rtcal_pkg::T_1HZ] : sq_rate;

	// settings stay put on backup; only the output is withheld
	wire sq_act = sqw && !bk_s;
	wire alm_lvl = !(|flag);
	assign next_mfp = sq_act ? sq_out : alm_lvl;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			multi_function_pin <= rtcal_pkg::MFP_IDLE;
		else
			multi_function_pin <= next_mfp;
	end

	// readback; unmapped offsets read zero
	wire [7:0] rd_mux =
		(reg_addr == rtcal_pkg::A_CTRL) ?
			{rtcal_pkg::CTRL_B7, ctrl} :
		(reg_addr == rtcal_pkg::A0_SEC) ? {1'b0, a0_sec} :
		(reg_addr == rtcal_pkg::A0_MIN) ? {1'b0, a0_min} :
		(reg_addr == rtcal_pkg::A0_HOUR) ?
			{1'b0, now_hour[rtcal_pkg::H_FMT], a0_hour} :
		(reg_addr == rtcal_pkg::A0_WKD) ?
			{1'b0, a0_sel, flag[0], a0_wkd} :
		(reg_addr == rtcal_pkg::A0_DATE) ? {2'h0, a0_date} :
		(reg_addr == rtcal_pkg::A0_MTH) ? {3'h0, a0_mth} :
		(reg_addr == rtcal_pkg::A1_HSEC) ? a1_hsec :
		(reg_addr == rtcal_pkg::A1_SEC) ? {1'b0, a1_sec} :
		(reg_addr == rtcal_pkg::A1_MIN) ? {1'b0, a1_min} :
		(reg_addr == rtcal_pkg::A1_HOUR) ?
			{1'b0, now_hour[rtcal_pkg::H_FMT], a1_hour} :
		(reg_addr == rtcal_pkg::A1_WKD) ?
			{1'b0, a1_sel, flag[1], a1_wkd} :
		(reg_addr == rtcal_pkg::A1_DATE) ? {2'h0, a1_date} :
		8'h00;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_set;
		hit[0] |=> flag[0] ##1 (flag[0] || $past(clr0));
	endproperty
	a_set: assert property (p_set)
		else $error("flag 0 not set by match");

	property p_hold;
		flag[1] && !clr1 |=> flag[1];
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag 1 lost without clear");

	property p_clear;
		clr0 && !hit[0] |=> !flag[0];
	endproperty
	a_clear: assert property (p_clear)
		else $error("flag 0 not cleared by zero write");

	property p_noset;
		!flag[1] && !hit[1] |=> !flag[1];
	endproperty
	a_noset: assert property (p_noset)
		else $error("flag 1 set without match");

	property p_alarm_pin;
		!sq_act && (|flag) |=> !multi_function_pin;
	endproperty
	a_alarm_pin: assert property (p_alarm_pin)
		else $error("pin not low with flag set");

	property p_backup;
		bk_s && !(|flag) |=> multi_function_pin;
	endproperty
	a_backup: assert property (p_backup)
		else $error("square wave on pin during backup");

	property p_div8;
		sq_act && !crs && fs == rtcal_pkg::FS_DIV8
			|=> multi_function_pin == $past(div[rtcal_pkg::T_DIV8]);
	endproperty
	a_div8: assert property (p_div8)
		else $error("divide by eight tap not on pin");

	property p_coarse;
		sq_act && crs
			|=> multi_function_pin == $past(div[rtcal_pkg::T_1HZ]);
	endproperty
	a_coarse: assert property (p_coarse)
		else $error("coarse trim not giving 1 hz tap");

	property p_raw;
		sq_act && !crs && fs == 2'h3
			|=> multi_function_pin == $past(raw_tog);
	endproperty
	a_raw: assert property (p_raw)
		else $error("undivided rate not from raw source");

	property p_ctrl_rd;
		reg_rd && reg_addr == rtcal_pkg::A_CTRL |=> reg_rdata[7];
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd)
		else $error("control bit 7 not read as one");
endmodule

// File: tb/rtcal_host.sv
/*
 * host model: writes and reads on the strobe register port.
 * assumes the shared clk; changes its outputs at the falling edge.
 */
`timescale 1ns/1ps
module rtcal_host (
	// clock
	input  wire logic       clk,
	// register port
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd
);
	logic [7:0] ctrl;

	initial begin
		ctrl = 8'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one strobe cycle; data inverted once released
	task automatic acc(input bit w, input logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = ~d;
	endtask

	// alarm off first so a half-loaded setting never matches
	task automatic arm(input bit n, input logic [2:0] s);
		logic [7:0] b;
		b = n ? rtcal_pkg::A1_SEC : rtcal_pkg::A0_SEC;
		ctrl[4 + n] = 1'b0;
		acc(1'b1, rtcal_pkg::A_CTRL, ctrl);
		acc(1'b1, b + 8'h03, {1'b0, s, 1'b0, 3'h3});
		acc(1'b1, b, 8'h12);
		acc(1'b1, b + 8'h01, 8'h34);
		acc(1'b1, b + 8'h02, 8'h05);
		acc(1'b1, b + 8'h04, 8'h15);
		acc(1'b1, n ? 8'h12 : 8'h11, n ? 8'h56 : 8'h06);
		ctrl[4 + n] = 1'b1;
		acc(1'b1, rtcal_pkg::A_CTRL, ctrl);
	endtask
endmodule

// File: tb/tb_top.sv
/*
 * self-checking bench for the alarm and multi-function pin block.
 * assumes the host model drives the register port.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("[ERR] %0t got %h exp %h", $time, g, e); \
	end \
end
module tb_top;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       reg_wr, reg_rd;
	logic       time_tick = 1'b0;
	logic [7:0] now_hsec = 8'h00;
	logic [6:0] now_sec = 7'h00;
	logic [6:0] now_min = 7'h00;
	logic [7:0] now_hour = 8'h00;
	logic [2:0] now_weekday_value = 3'h1;
	logic [5:0] now_date = 6'h01;
	logic [4:0] now_month = 5'h01;
	logic       osc_edge = 1'b0;
	logic       trim_edge = 1'b0;
	logic       on_backup = 1'b0;
	logic       pin, ext_en, crs_en, pin_q;
	logic       rd_q = 1'b0;
	logic       obs = 1'b0;
	logic [7:0] obs_val, e, d, tog, ad;
	logic       x1 = 1'b0;
	logic [7:0] q[$];
	int         miscompares = 0;
	int         checks_done = 0;
	logic [7:0] ra[9] = '{8'h08, 8'h0f, 8'h16, 8'h10, 8'h17, 8'h11,
		8'h0c, 8'h12, 8'h20};
	logic [7:0] rv[9] = '{8'h80, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
		8'h00, 8'h00, 8'h00};
	logic [7:0] wm[9] = '{8'h7f, 8'h7f, 8'h3f, 8'h77, 8'h3f, 8'h1f,
		8'hff, 8'h77, 8'h00};

	always #20 clk = ~clk;

	rtcal_host i_rtcal_host (.clk(clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

	rtcal_top i_rtcal_top (.clk(clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .time_tick(time_tick),
		.now_hsec(now_hsec), .now_sec(now_sec), .now_min(now_min),
		.now_hour(now_hour), .now_weekday_value(now_weekday_value), .now_date(now_date),
		.now_month(now_month), .osc_edge(osc_edge),
		.trim_edge(trim_edge), .crystal_input_pin(x1),
		.on_backup(on_backup), .multi_function_pin(pin),
		.external_clock_input_enable(ext_en),
		.coarse_trim_enable(crs_en));

	// results in arrival order against the oldest note
	always @(posedge clk) begin
		if (rd_q || obs) begin
			e = q.pop_front();
			`CHK(rd_q ? reg_rdata : obs_val, e)
		end
		rd_q = reg_rd;
		if (pin !== pin_q)
			tog++;
		pin_q = pin;
	end

	task automatic exp_rd(input logic [7:0] a, x);
		q.push_back(x);
		i_rtcal_host.acc(1'b0, a, 8'h00);
	endtask

	task automatic exp_obs(input logic [7:0] v, x);
		@(negedge clk);
		q.push_back(x);
		obs_val = v;
		obs = 1'b1;
		@(negedge clk);
		obs = 1'b0;
	endtask

	// fields set in m equal the alarm values, the rest differ
	task automatic tk(input logic [6:0] m);
		@(negedge clk);
		now_sec = m[0] ? 7'h12 : 7'h00;
		now_min = m[1] ? 7'h34 : 7'h00;
		now_hour = m[2] ? 8'h45 : 8'h40;
		now_weekday_value = m[3] ? 3'h3 : 3'h1;
		now_date = m[4] ? 6'h15 : 6'h01;
		now_hsec = m[5] ? 8'h56 : 8'h00;
		now_month = m[6] ? 5'h06 : 5'h01;
		time_tick = 1'b1;
		@(negedge clk);
		time_tick = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic case_run(input bit n, input logic [2:0] s,
		input logic [6:0] m, input bit hit);
		logic [7:0] wa;
		wa = n ? rtcal_pkg::A1_WKD : rtcal_pkg::A0_WKD;
		i_rtcal_host.arm(n, s);
		tk(7'h00);
		tk(m);
		// still equal: no second hit, flag must simply stay
		tk(m);
		exp_rd(wa, {1'b0, s, hit, 3'h3});
		i_rtcal_host.acc(1'b1, wa, {1'b0, s, 1'b0, 3'h3});
		tk(m);
		exp_rd(wa, {1'b0, s, 4'h3});
	endtask

	// 32 source edges, then the pin's toggle count
	task automatic sw_run(input logic [7:0] c, input bit raw, bak,
		input logic [7:0] x);
		@(negedge clk);
		on_backup = bak;
		i_rtcal_host.acc(1'b1, rtcal_pkg::A_CTRL, c);
		repeat (6) @(negedge clk);
		tog = 8'h00;
		repeat (32) begin
			@(negedge clk);
			osc_edge = raw;
			trim_edge = !raw;
			// pin clock runs always; only the external mode may use it
			x1 = !x1;
			@(negedge clk);
			osc_edge = 1'b0;
			trim_edge = 1'b0;
		end
		repeat (4) @(negedge clk);
		exp_obs(tog, x);
	endtask

	task automatic finish_test;
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		finish_test();
	end

	initial begin
		void'($urandom(72));
		repeat (3) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		exp_obs({7'h00, pin}, 8'h01);
		for (int i = 0; i < 9; i++)
			exp_rd(ra[i], rv[i]);
		// write masks: read-only, unimplemented and unmapped bits
		for (int i = 0; i < 9; i++) begin
			d = 8'($urandom);
			// only legal host values: select, weekday, bcd ones
			if (d[6:4] == 3'h6)
				d[4] = 1'b1;
			if (d[2:0] == 3'h0)
				d[0] = 1'b1;
			if (d[3] && d[2:1] != 2'h0)
				d[2:1] = 2'h0;
			ad = 8'h0c + 8'(i);
			if (i > 6)
				ad = i == 7 ? rtcal_pkg::A1_WKD : 8'h20;
			i_rtcal_host.acc(1'b1, ad, d);
			exp_rd(ad, d & wm[i]);
		end
		i_rtcal_host.acc(1'b1, 8'h20, 8'hff);
		exp_rd(8'h20, 8'h00);
		i_rtcal_host.acc(1'b1, rtcal_pkg::A_CTRL, 8'h0c);
		exp_rd(rtcal_pkg::A_CTRL, 8'h8c);
		exp_obs({6'h00, ext_en, crs_en}, 8'h03);
		// every select on both alarms; 101/110 see all fields equal
		for (int n = 0; n < 2; n++)
			for (int s = 0; s < 8; s++)
				case_run(n[0], s[2:0], s < 5 ? 7'h01 << s :
					(n == 1 ? 7'h3f : 7'h7f),
					s != 6 && (s != 5 || n == 1));
		case_run(1'b0, 3'h7, 7'h3f, 1'b0);
		i_rtcal_host.arm(1'b0, 3'h0);
		i_rtcal_host.acc(1'b1, rtcal_pkg::A_CTRL, 8'h00);
		tk(7'h00);
		tk(7'h01);
		exp_rd(rtcal_pkg::A0_WKD, 8'h03);
		// both alarms pull the pin, released only when both clear
		i_rtcal_host.arm(1'b0, 3'h0);
		i_rtcal_host.arm(1'b1, 3'h0);
		tk(7'h00);
		tk(7'h01);
		exp_obs({7'h00, pin}, 8'h00);
		on_backup = 1'b1;
		repeat (4) @(negedge clk);
		exp_obs({7'h00, pin}, 8'h00);
		i_rtcal_host.acc(1'b1, rtcal_pkg::A0_WKD, 8'h03);
		repeat (3) @(negedge clk);
		exp_obs({7'h00, pin}, 8'h00);
		i_rtcal_host.acc(1'b1, rtcal_pkg::A1_WKD, 8'h03);
		repeat (3) @(negedge clk);
		exp_obs({7'h00, pin}, 8'h01);
		sw_run(8'h41, 1'b0, 1'b0, 8'd4);
		sw_run(8'h42, 1'b0, 1'b0, 8'd8);
		sw_run(8'h43, 1'b1, 1'b0, 8'd32);
		sw_run(8'h43, 1'b0, 1'b0, 8'd0);
		sw_run(8'h4b, 1'b0, 1'b0, 8'd32);
		sw_run(8'h45, 1'b0, 1'b0, 8'd0);
		sw_run(8'h41, 1'b0, 1'b1, 8'd0);
		sw_run(8'h41, 1'b0, 1'b0, 8'd4);
		exp_rd(rtcal_pkg::A_CTRL, 8'hc1);
		finish_test();
	end
endmodule
